// ### src/tsl_cfg.svh
`ifndef TSL_CFG_SVH
`define TSL_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define TSL_CLK_NS        10
`define TSL_LINK_CLK_NS   32
`define TSL_TICK_NS       4096000
`define TSL_TICK_CYC      (`TSL_TICK_NS / `TSL_CLK_NS)
`define TSL_BIT_NS        1000
// a least time: round the bit period up to whole link cycles
`define TSL_BIT_LCYC      ((`TSL_BIT_NS + `TSL_LINK_CLK_NS - 1) / `TSL_LINK_CLK_NS)
`define TSL_HALF_LCYC     (`TSL_BIT_LCYC / 2)
`define TSL_SETTLE_NS     2000
`define TSL_SETTLE_CYC    ((`TSL_SETTLE_NS + `TSL_CLK_NS - 1) / `TSL_CLK_NS)

// ----------------------------------------------------------------------
// subdivider and lamp map
// ----------------------------------------------------------------------
`define TSL_SUBDIV_RELOAD 8'hf4
`define TSL_FAST_BIT      0
`define TSL_SLOW_BIT      7
`define TSL_MAP_LF        0
`define TSL_MAP_RF        1
`define TSL_MAP_LD        2
`define TSL_MAP_RD        3
`define TSL_MAP_LR        4
`define TSL_MAP_RR        5
`define TSL_MAP_RESET     6'h00
`define TSL_LAMPS         6
`define TSL_BITS_PER_BYTE 8

`endif

// ### src/tsl_pkg.sv
package tsl_pkg;

  // continuity check sequencer
  typedef enum logic [1:0] {
    TSL_CK_IDLE   = 2'b01,
    TSL_CK_SETTLE = 2'b10
  } tsl_ck_e;

  // serial shifter sequencer
  typedef enum logic [2:0] {
    TSL_SH_IDLE  = 3'b001,
    TSL_SH_SHIFT = 3'b010,
    TSL_SH_LATCH = 3'b100
  } tsl_sh_e;

  typedef logic [7:0] tsl_byte_t;
  typedef logic [5:0] tsl_map_t;

endpackage : tsl_pkg

// ### src/tsl_shift_out.sv
`timescale 1ns/1ns
`include "tsl_cfg.svh"

module tsl_shift_out
  import tsl_pkg::*;
(
  // link clock domain
  input  wire logic      link_clk,
  input  wire logic      reset_n,
  input  wire logic      clk_en,
  // word handshake from the system clock domain
  input  wire logic      req_tgl,
  input  wire tsl_byte_t req_data,
  output logic           ack_tgl,
  // shift register driver pins
  output logic           shift_data,
  output logic           shift_clk,
  output logic           shift_latch
);

  localparam int BIT_LCYC  = `TSL_BIT_LCYC;
  localparam int HALF_LCYC = `TSL_HALF_LCYC;

  tsl_sh_e    st_r;
  tsl_byte_t  sr_r;
  logic [2:0] bit_r;
  logic [5:0] div_r;
  logic       ce_meta_r;
  logic       ce_r;
  logic       rq_meta_r;
  logic       rq_sync_r;
  logic       rq_seen_r;

  // ----------------------------------------------------------------------
  // crossings into the link domain
  // ----------------------------------------------------------------------
  // clock enable and request toggle each pass two flops
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ce_meta_r <= 1'b0;
      ce_r      <= 1'b0;
      rq_meta_r <= 1'b0;
      rq_sync_r <= 1'b0;
    end
    else
    begin
      ce_meta_r <= clk_en;
      ce_r      <= ce_meta_r;
      rq_meta_r <= req_tgl;
      rq_sync_r <= rq_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // shifter: lsb first, data set while clock low, taken on rising edge
  // ----------------------------------------------------------------------
  // req_data is held by the sender until the ack toggle returns
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r        <= TSL_SH_IDLE;
      sr_r        <= 8'h00;
      bit_r       <= 3'h0;
      div_r       <= 6'h00;
      rq_seen_r   <= 1'b0;
      ack_tgl     <= 1'b0;
      shift_data  <= 1'b0;
      shift_clk   <= 1'b1;
      shift_latch <= 1'b0;
    end
    else if (ce_r)
    begin
      unique case (st_r)
        TSL_SH_IDLE:
        begin
          if (rq_sync_r != rq_seen_r)
          begin
            rq_seen_r  <= rq_sync_r;
            sr_r       <= req_data;
            shift_data <= req_data[0];
            shift_clk  <= 1'b0;
            bit_r      <= 3'h0;
            div_r      <= 6'h00;
            st_r       <= TSL_SH_SHIFT;
          end
        end
        TSL_SH_SHIFT:
        begin
          div_r <= div_r + 6'h01;
          if (div_r == 6'(HALF_LCYC - 1))
            shift_clk <= 1'b1;
          if (div_r == 6'(BIT_LCYC - 1))
          begin
            div_r <= 6'h00;
            if (bit_r == 3'h7)
            begin
              shift_latch <= 1'b1;
              st_r        <= TSL_SH_LATCH;
            end
            else
            begin
              bit_r      <= bit_r + 3'h1;
              sr_r       <= {1'b0, sr_r[7:1]};
              shift_data <= sr_r[1];
              shift_clk  <= 1'b0;
            end
          end
        end
        TSL_SH_LATCH:
        begin
          // one strobe lets the driver hold its outputs while shifting
          shift_latch <= 1'b0;
          ack_tgl     <= ~ack_tgl;
          st_r        <= TSL_SH_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  localparam int BYTE_LCYC = `TSL_BITS_PER_BYTE * `TSL_BIT_LCYC;
  logic [3:0]  rise_cnt_r;
  logic [11:0] byte_cyc_r;
  logic        clk_q_r;

  // helper: rising shift clock edges and cycles spent in one byte
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rise_cnt_r <= 4'h0;
      byte_cyc_r <= 12'h000;
      clk_q_r    <= 1'b1;
    end
    else if (ce_r)
    begin
      clk_q_r <= shift_clk;
      if (st_r == TSL_SH_IDLE)
      begin
        rise_cnt_r <= 4'h0;
        byte_cyc_r <= 12'h000;
      end
      else
      begin
        byte_cyc_r <= byte_cyc_r + 12'h001;
        if (shift_clk && !clk_q_r)
          rise_cnt_r <= rise_cnt_r + 4'h1;
      end
    end
  end

  eight_pulses_a: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    shift_latch |-> rise_cnt_r == 4'h8)
    else $error("byte did not carry eight shift clock pulses");

  byte_time_a: assert property (
    @(posedge link_clk) disable iff (!reset_n)
    shift_latch |-> byte_cyc_r == 12'(BYTE_LCYC))
    else $error("byte transfer time is not eight bit periods");

endmodule // tsl_shift_out

// ### src/tsl_lamp_ctrl.sv
// Function
// - faint term is parking switch AND dimming wave, shared by front and rear
// - left dash lamp is (left lever OR hazard) AND slow blink bit
// - left front lamp is left dash term OR faint term
// - left rear on with brake and no left turn, OR dash OR faint
// - right side lamps follow the left equations using the right lever
// - lamps refresh every tick (in serial mode only while the buffer has room), far above flicker rate
// - optional duty select gives seven dimming duties in eighths
// - duty 62.5 percent is (bit1 AND bit0) OR bit2 of subdivider
// - each lamp byte shifts out serially with exactly eight clock pulses
// - serial shift takes 32 link cycles per bit, 1024 ns at a 32 ns link clock, eight per byte
// - serial expansion mode is active straight out of reset
// - lamp byte order LF,RF,LD,RD,LR,RR, sent after full computation
// - continuity test turns one lamp off, low sense means circuit intact
// - fast bit is subdivider bit 0, slow bit is subdivider bit 7
// - subdivider loads 244, decrements per tick, reloads on reaching zero
`timescale 1ns/1ns
`include "tsl_cfg.svh"

module tsl_lamp_ctrl
  import tsl_pkg::*;
#(
  parameter int TICK_CYCLES = `TSL_TICK_CYC
)
(
  // system clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // link clock for the serial driver
  input  wire logic        link_clk,
  // switch inputs, asynchronous
  input  wire logic        sw_left,
  input  wire logic        sw_right,
  input  wire logic        sw_hazard,
  input  wire logic        sw_brake,
  input  wire logic        sw_park,
  // continuity sense, low when the switched-off lamp is intact
  input  wire logic        lamp_sense,
  // configuration
  input  wire logic [2:0]  dim_sel,
  input  wire logic [19:0] tick_period,
  input  wire logic        parallel_sel,
  input  wire logic        check_en,
  input  wire logic [5:0]  fault_clear,
  // lamp outputs
  output logic             lamp_front_l,
  output logic             lamp_front_r,
  output logic             lamp_dash_l,
  output logic             lamp_dash_r,
  output logic             lamp_rear_l,
  output logic             lamp_rear_r,
  // serial driver pins
  output logic             shift_data,
  output logic             shift_clk,
  output logic             shift_latch,
  // status
  output logic [5:0]       fault_flags,
  output logic             check_busy,
  output logic             ser_mode
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 6;
  logic [NSYNC-1:0] pin_in;
  logic [NSYNC-1:0] pin_meta_r;
  logic [NSYNC-1:0] pin_sync_r;
  logic left_s, right_s, haz_s, brake_s, park_s, sense_s;

  assign pin_in = {lamp_sense, sw_park, sw_brake, sw_hazard, sw_right,
                   sw_left};

  // two flops per pin; only the second is read by logic
  for (genvar g = 0; g < NSYNC; g++)
  begin : g_sync
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        pin_meta_r[g] <= 1'b0;
        pin_sync_r[g] <= 1'b0;
      end
      else if (clk_en)
      begin
        pin_meta_r[g] <= pin_in[g];
        pin_sync_r[g] <= pin_meta_r[g];
      end
    end
  end

  assign {sense_s, park_s, brake_s, haz_s, right_s, left_s} = pin_sync_r;

  // ----------------------------------------------------------------------
  // tick prescaler and subdivider
  // ----------------------------------------------------------------------
  logic [19:0] pre_r;
  logic [19:0] tick_lim;
  logic        tick_r;
  logic [7:0]  sub_r;

  // zero on tick_period selects the default interval
  assign tick_lim = (tick_period == 20'h00000) ? 20'(TICK_CYCLES - 1)
                                               : tick_period - 20'h00001;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_r  <= 20'h00000;
      tick_r <= 1'b0;
    end
    else if (clk_en)
    begin
      tick_r <= 1'b0;
      pre_r  <= pre_r + 20'h00001;
      if (pre_r >= tick_lim)
      begin
        pre_r  <= 20'h00000;
        tick_r <= 1'b1;
      end
    end
  end

  // decrement then reload on zero, as a count-down loop would
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      sub_r <= `TSL_SUBDIV_RELOAD;
    else if (clk_en && tick_r)
      sub_r <= (sub_r == 8'h01) ? `TSL_SUBDIV_RELOAD
                                : sub_r - 8'h01;
  end

  // ----------------------------------------------------------------------
  // lamp equations
  // ----------------------------------------------------------------------
  logic     fast_toggle_bit, slow_blink_bit, dim_wave, faint_lamp_term;
  logic     dash_l, dash_r;
  tsl_map_t map_nxt;

  assign fast_toggle_bit = sub_r[`TSL_FAST_BIT];
  assign slow_blink_bit  = sub_r[`TSL_SLOW_BIT];

  // duty n/8 is on for the top n of the eight low-bit states
  assign dim_wave = (dim_sel == 3'h0) ? fast_toggle_bit
                  : ({1'b0, sub_r[2:0]} >= (4'h8 - {1'b0, dim_sel}));

  assign faint_lamp_term = park_s & dim_wave;
  assign dash_l = (left_s | haz_s) & slow_blink_bit;
  assign dash_r = (right_s | haz_s) & slow_blink_bit;

  always_comb
  begin
    map_nxt                = `TSL_MAP_RESET;
    map_nxt[`TSL_MAP_LD]   = dash_l;
    map_nxt[`TSL_MAP_RD]   = dash_r;
    map_nxt[`TSL_MAP_LF]   = dash_l | faint_lamp_term;
    map_nxt[`TSL_MAP_RF]   = dash_r | faint_lamp_term;
    map_nxt[`TSL_MAP_LR]   = (brake_s & ~left_s) | dash_l
                           | faint_lamp_term;
    map_nxt[`TSL_MAP_RR]   = (brake_s & ~right_s) | dash_r
                           | faint_lamp_term;
  end

  // ----------------------------------------------------------------------
  // update scheduling and lamp registers
  // ----------------------------------------------------------------------
  logic     pend_r, upd_go, in_valid, in_rdy;
  logic     ser_mode_r;
  tsl_map_t map_r;
  tsl_map_t lamp_r;
  tsl_ck_e  ck_st_r;
  logic [2:0] idx_r;

  // a full buffer stalls the update instead of dropping a map
  assign upd_go   = pend_r && (in_rdy || !ser_mode_r);
  assign in_valid = upd_go && ser_mode_r;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_r     <= 1'b0;
      ser_mode_r <= 1'b1;
      map_r      <= `TSL_MAP_RESET;
    end
    else if (clk_en)
    begin
      ser_mode_r <= ~parallel_sel;
      if (tick_r)
        pend_r <= 1'b1;
      else if (upd_go)
        pend_r <= 1'b0;
      if (upd_go)
        map_r <= map_nxt;
    end
  end

  // pins show the map, or the one-lamp-off pattern during a check
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lamp_r <= `TSL_MAP_RESET;
    else if (clk_en)
    begin
      if (ck_st_r == TSL_CK_SETTLE)
        lamp_r <= ~(6'h01 << idx_r);
      else
        lamp_r <= upd_go ? map_nxt : map_r;
    end
  end

  // ----------------------------------------------------------------------
  // continuity check, run at each subdivider reload
  // ----------------------------------------------------------------------
  logic [7:0] wait_r;
  logic [5:0] fault_r;
  logic [5:0] fault_set;

  assign fault_set = (ck_st_r == TSL_CK_SETTLE
                      && wait_r == 8'(`TSL_SETTLE_CYC - 1) && sense_s)
                     ? (6'h01 << idx_r) : 6'h00;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ck_st_r <= TSL_CK_IDLE;
      idx_r   <= 3'h0;
      wait_r  <= 8'h00;
    end
    else if (clk_en)
    begin
      unique case (ck_st_r)
        TSL_CK_IDLE:
        begin
          if (check_en && tick_r && sub_r == 8'h01)
          begin
            idx_r   <= 3'h0;
            wait_r  <= 8'h00;
            ck_st_r <= TSL_CK_SETTLE;
          end
        end
        TSL_CK_SETTLE:
        begin
          // the sense pin needs time after the lamp switches off
          wait_r <= wait_r + 8'h01;
          if (wait_r == 8'(`TSL_SETTLE_CYC - 1))
          begin
            wait_r <= 8'h00;
            idx_r  <= idx_r + 3'h1;
            if (idx_r == 3'(`TSL_LAMPS - 1))
              ck_st_r <= TSL_CK_IDLE;
          end
        end
      endcase
    end
  end

  // sticky flags; a new failure wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      fault_r <= 6'h00;
    else if (clk_en)
      fault_r <= (fault_r & ~fault_clear) | fault_set;
  end

  // ----------------------------------------------------------------------
  // two-entry buffer and crossing to the link domain
  // ----------------------------------------------------------------------
  localparam int DEPTH = 2;
  tsl_byte_t  mem_r [DEPTH];
  logic       wr_ptr_r, rd_ptr_r;
  logic [1:0] cnt_r;
  logic       out_valid, out_rdy, push, pop;
  tsl_byte_t  hold_r;
  logic       req_tgl_r, ack_meta_r, ack_sync_r, ack_seen_r, ack_tgl;

  assign in_rdy    = (cnt_r != 2'(DEPTH));
  assign out_valid = (cnt_r != 2'h0);
  assign out_rdy   = (req_tgl_r == ack_seen_r);
  assign push      = in_valid && in_rdy;
  assign pop       = out_valid && out_rdy;

  // the map is stored whole after all six lamps are computed
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= 8'h00;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem_r[wr_ptr_r] <= {2'b00, map_nxt};
        wr_ptr_r        <= ~wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end

  // toggle handshake; hold_r stays put until the ack toggle returns
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hold_r     <= 8'h00;
      req_tgl_r  <= 1'b0;
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
      ack_seen_r <= 1'b0;
    end
    else if (clk_en)
    begin
      ack_meta_r <= ack_tgl;
      ack_sync_r <= ack_meta_r;
      ack_seen_r <= ack_sync_r;
      if (pop)
      begin
        hold_r    <= mem_r[rd_ptr_r];
        req_tgl_r <= ~req_tgl_r;
      end
    end
  end

  tsl_shift_out u_shift (
    .link_clk    (link_clk),
    .reset_n     (reset_n),
    .clk_en      (clk_en),
    .req_tgl     (req_tgl_r),
    .req_data    (hold_r),
    .ack_tgl     (ack_tgl),
    .shift_data  (shift_data),
    .shift_clk   (shift_clk),
    .shift_latch (shift_latch)
  );

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign lamp_front_l = lamp_r[`TSL_MAP_LF];
  assign lamp_front_r = lamp_r[`TSL_MAP_RF];
  assign lamp_dash_l  = lamp_r[`TSL_MAP_LD];
  assign lamp_dash_r  = lamp_r[`TSL_MAP_RD];
  assign lamp_rear_l  = lamp_r[`TSL_MAP_LR];
  assign lamp_rear_r  = lamp_r[`TSL_MAP_RR];
  assign fault_flags  = fault_r;
  assign check_busy   = ck_st_r[1];
  assign ser_mode     = ser_mode_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence upd_s;
    clk_en && upd_go;
  endsequence

  faint_term_a: assert property (
    (clk_en && upd_go && dim_sel == 3'h0 && !left_s && !haz_s)
    |=> map_r[`TSL_MAP_LF] == $past(park_s & sub_r[0]))
    else $error("front lamp does not follow park and fast bit");

  dash_left_a: assert property (
    upd_s |=> map_r[`TSL_MAP_LD] == $past((left_s | haz_s) & sub_r[7]))
    else $error("left dash lamp wrong");

  front_left_a: assert property (
    upd_s |=> map_r[`TSL_MAP_LF]
              == ($past(faint_lamp_term) | map_r[`TSL_MAP_LD]))
    else $error("left front lamp wrong");

  rear_brake_a: assert property (
    (upd_s ##0 (brake_s && !left_s)) |=> map_r[`TSL_MAP_LR])
    else $error("left rear not on while braking");

  right_side_a: assert property (
    upd_s |=> map_r[`TSL_MAP_RR] == $past((brake_s & ~right_s)
              | ((right_s | haz_s) & sub_r[7]) | faint_lamp_term))
    else $error("right rear lamp wrong");

  duty_five_a: assert property (
    (dim_sel == 3'h5) |-> dim_wave == ((sub_r[1] & sub_r[0]) | sub_r[2]))
    else $error("62.5 percent wave wrong");

  sub_reload_a: assert property (
    (clk_en && tick_r && sub_r == 8'h01) |=> sub_r == `TSL_SUBDIV_RELOAD)
    else $error("subdivider did not reload");

  // a tick in the same cycle re-arms pend, a check overrides the pins
  upd_follow_a: assert property (
    (clk_en && upd_go && !tick_r && ck_st_r == TSL_CK_IDLE)
    |=> !pend_r && lamp_r == map_r)
    else $error("pending update was not applied");

  test_pattern_a: assert property (
    (clk_en && ck_st_r == TSL_CK_SETTLE) |=> $countones(lamp_r) == 5)
    else $error("check pattern is not one lamp off");

  sticky_fault_a: assert property (
    clk_en |=> (fault_r & $past(fault_r & ~fault_clear))
               == $past(fault_r & ~fault_clear))
    else $error("fault flag lost without clear");

endmodule // tsl_lamp_ctrl

// ### dv/tsl_drv_model.sv
`timescale 1ns/1ns

module tsl_drv_model
(
  // serial driver pins
  input  wire logic       shift_clk,
  input  wire logic       shift_data,
  input  wire logic       shift_latch,
  // lamp pins in map order, lamps made open
  input  wire logic [5:0] lamp_pins,
  input  wire logic [5:0] open_mask,
  // sense line and captured byte
  output logic            lamp_sense,
  output logic [7:0]      out_q,
  output int              byte_cnt,
  output int              edge_cnt,
  output time             span
);
  // --------------------------------------------------
  // shift register driver with output latch
  // --------------------------------------------------
  logic [7:0] sh_r;
  int         rise_n = 0;
  int         base_n = 0;
  time        t_fall;
  time        t_rise;

  // an unlit lamp that conducts pulls sense low
  assign lamp_sense = |(~lamp_pins & open_mask);
  // lsb first, taken on the rising shift clock
  always @(posedge shift_clk)
  begin
    sh_r   <= {shift_data, sh_r[7:1]};
    rise_n <= rise_n + 1;
    t_rise <= $time;
  end
  // first fall of a byte starts its timing
  always @(negedge shift_clk)
    if (rise_n == base_n)
      t_fall = $time;
  // outputs move only here, so no glitch while shifting
  initial byte_cnt = 0;
  always @(posedge shift_latch)
  begin
    out_q    <= sh_r;
    edge_cnt <= rise_n - base_n;
    span     <= t_rise - t_fall;
    base_n   <= rise_n;
    byte_cnt <= byte_cnt + 1;
  end
endmodule // tsl_drv_model

// ### dv/tb.sv
`timescale 1ns/1ns

module tb;
  // --------------------------------------------------
  // stimulus, design and far side
  // --------------------------------------------------
  localparam int TP = 20; // shortened tick, keeps the run short
  logic        ref_clk = 0;
  logic        link_clk = 0;
  logic        reset_n = 0;
  logic        clk_en = 1;
  logic        sw_left, sw_right, sw_hazard, sw_brake, sw_park;
  logic [2:0]  dim_sel = 0;
  logic [19:0] tick_period = TP;
  logic        parallel_sel = 1;
  logic        check_en = 0;
  logic [5:0]  fault_clear = 0, open_mask = 0, fault_flags, pins;
  logic        lamp_front_l, lamp_front_r, lamp_dash_l, lamp_dash_r;
  logic        lamp_rear_l, lamp_rear_r, lamp_sense, check_busy;
  logic        shift_data, shift_clk, shift_latch, ser_mode;
  logic [7:0]  out_q;
  int          byte_cnt, edge_cnt, fails = 0, check_count = 0;
  int          seed = 32'hba64, cyc = 0, t0, cnt;
  time         span;

  assign pins = {lamp_rear_r, lamp_rear_l, lamp_dash_r, lamp_dash_l,
                 lamp_front_r, lamp_front_l};
  always #5 ref_clk = ~ref_clk;
  // cycle count, times lamp edges exactly
  always @(negedge ref_clk) cyc <= cyc + 1;
  // link clock, phase unrelated to the system clock
  initial
  begin
    #3;
    forever #16 link_clk = ~link_clk;
  end

  tsl_lamp_ctrl dut_u (.ref_clk, .reset_n, .clk_en, .link_clk, .sw_left,
    .sw_right, .sw_hazard, .sw_brake, .sw_park, .lamp_sense, .dim_sel,
    .tick_period, .parallel_sel, .check_en, .fault_clear, .lamp_front_l,
    .lamp_front_r, .lamp_dash_l, .lamp_dash_r, .lamp_rear_l, .lamp_rear_r,
    .shift_data, .shift_clk, .shift_latch, .fault_flags, .check_busy,
    .ser_mode);
  tsl_drv_model drv_u (.shift_clk, .shift_data, .shift_latch,
    .lamp_pins(pins), .open_mask, .lamp_sense, .out_q, .byte_cnt,
    .edge_cnt, .span);

  // --------------------------------------------------
  // checking helpers
  // --------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s: saw %0h want %0h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a wait that runs out is a mismatch and ends the run
  task automatic wait_lvl(input int sel, input logic v, input int lim);
    int k;
    for (k = 0; k < lim; k++)
    begin
      @(negedge ref_clk);
      if ((sel == 0 ? lamp_dash_l : sel == 1 ? lamp_front_r :
           sel == 2 ? check_busy : byte_cnt[0]) === v)
        break;
    end
    if (k >= lim)
    begin
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask

  // map {rr,lr,rd,ld,rf,lf} for given blink and faint bits
  function automatic logic [5:0] exp_map(input logic s, f);
    logic fl, dl, dr;
    fl = sw_park & f;
    dl = (sw_left | sw_hazard) & s;
    dr = (sw_right | sw_hazard) & s;
    return {dr | fl | (sw_brake & ~sw_right),
            dl | fl | (sw_brake & ~sw_left), dr, dl, dr | fl, dl | fl};
  endfunction

  // blink phase is not seen, so any of the four phases fits
  function automatic logic fits(input logic [5:0] m);
    fits = 0;
    for (int k = 0; k < 4; k++)
      fits |= (m === exp_map(k[1], k[0]));
  endfunction

  task automatic rnd_sw;
    {sw_left, sw_right, sw_hazard, sw_brake, sw_park} = 5'($random(seed));
    if (sw_left)
      sw_right = 0;
  endtask

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial
  begin
    {sw_left, sw_right, sw_hazard, sw_brake, sw_park} = 5'h00;
    repeat (10) @(negedge ref_clk);
    chk(pins, 6'h00, "reset lamps");
    chk(ser_mode, 1'b1, "reset mode");
    reset_n = 1;
    // faint lamp flips each tick with the fast bit
    sw_park = 1;
    wait_lvl(1, 1'b1, 200);
    t0 = cyc;
    wait_lvl(1, 1'b0, 200);
    chk(cyc - t0, TP, "tick");
    $display("test tick done");
    // slow low half is far from reload: 8 ticks give every duty exactly
    sw_left = 1;
    wait_lvl(0, 1'b1, 6000);
    wait_lvl(0, 1'b0, 6000);
    t0 = cyc;
    repeat (TP / 2) @(negedge ref_clk);
    for (int d = 1; d < 8; d++)
    begin
      dim_sel = 3'(d);
      cnt = 0;
      repeat (8)
      begin
        repeat (TP) @(negedge ref_clk);
        cnt += lamp_front_r;
      end
      chk(cnt, d, "duty");
    end
    dim_sel = 0;
    wait_lvl(0, 1'b1, 3000);
    chk(cyc - t0, 127 * TP, "slow low");
    t0 = cyc;
    wait_lvl(0, 1'b0, 3000);
    chk(cyc - t0, 117 * TP, "slow high");
    $display("test blink done");
    // continuity with lamp 3 open
    {sw_left, sw_park} = 2'b00;
    open_mask = 6'h08;
    check_en = 1;
    wait_lvl(2, 1'b1, 6000);
    repeat (100) @(negedge ref_clk);
    chk(pins, 6'h3e, "check pattern");
    wait_lvl(2, 1'b0, 1400);
    check_en = 0;
    repeat (50) @(negedge ref_clk);
    chk(fault_flags, 6'h08, "fault set");
    fault_clear = 6'h08;
    repeat (4) @(negedge ref_clk);
    fault_clear = 0;
    chk(fault_flags, 6'h00, "fault clear");
    $display("test continuity done");
    repeat (40)
    begin
      rnd_sw();
      repeat (3 * TP) @(negedge ref_clk);
      chk(fits(pins), 1'b1, "pin map");
    end
    // enable low: no tick, no update, pins hold
    clk_en = 0;
    t0 = pins;
    rnd_sw();
    repeat (3 * TP) @(negedge ref_clk);
    chk(pins, t0, "frozen");
    clk_en = 1;
    $display("test parallel done");
    // ticks outpace the shifter: buffer fills, updates stall
    parallel_sel = 0;
    repeat (6)
    begin
      rnd_sw();
      repeat (5)
        wait_lvl(3, ~byte_cnt[0], 3000);
      chk(ser_mode, 1'b1, "mode");
      chk(out_q[7:6], 2'b00, "top bits");
      chk(fits(out_q[5:0]), 1'b1, "byte map");
      chk(edge_cnt, 8, "pulses");
      chk(span >= 7168 && span <= 8192, 1'b1, "byte time");
    end
    $display("test serial done");
    final_report();
  end
endmodule // tb
